/* File: rtl/phy_cfg_pkg.sv */
// constants, register map and carrier types for the indicator and general config block
package phy_cfg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int IND_N = 4;
    localparam int IRQ_W = 3;
    localparam int CNT_W = 27;

    // register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_INDICATOR_POLARITY_OVERRIDE = 8'h19;
    localparam logic [ADDR_W-1:0] IDX_INDICATOR_BLINK_CONFIG = 8'h1a;
    localparam logic [ADDR_W-1:0] IDX_GENERAL_CONFIG_FOUR = 8'h1e;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR = 8'h21;
    localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE = 8'h22;
    localparam int BYTES_PER_REG = 4;
    localparam logic [ADDR_W-1:0] ADDR_INDICATOR_POLARITY_OVERRIDE =
        ADDR_W'(IDX_INDICATOR_POLARITY_OVERRIDE * BYTES_PER_REG);
    localparam logic [ADDR_W-1:0] ADDR_INDICATOR_BLINK_CONFIG =
        ADDR_W'(IDX_INDICATOR_BLINK_CONFIG * BYTES_PER_REG);
    localparam logic [ADDR_W-1:0] ADDR_GENERAL_CONFIG_FOUR =
        ADDR_W'(IDX_GENERAL_CONFIG_FOUR * BYTES_PER_REG);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = ADDR_W'(IDX_IRQ_STATUS * BYTES_PER_REG);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = ADDR_W'(IDX_IRQ_CLEAR * BYTES_PER_REG);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = ADDR_W'(IDX_IRQ_ENABLE * BYTES_PER_REG);

    // reset values and writable masks
    localparam logic [REG_W-1:0] RST_INDICATOR_POLARITY_OVERRIDE = 16'h4444;
    localparam logic [REG_W-1:0] RST_INDICATOR_BLINK_CONFIG = 16'h0002;
    localparam logic [REG_W-1:0] RST_GENERAL_CONFIG_FOUR = 16'h0012;
    localparam logic [REG_W-1:0] MASK_INDICATOR_POLARITY_OVERRIDE = 16'h7777;
    localparam logic [REG_W-1:0] MASK_INDICATOR_BLINK_CONFIG = 16'h0007;
    localparam logic [REG_W-1:0] MASK_GENERAL_CONFIG_RW = 16'hfff8;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

    // per-indicator nibble in the polarity/override register
    localparam int IND_NIBBLE = 4;
    localparam int POS_FORCE_ENABLE = 0;
    localparam int POS_FORCE_VALUE = 1;
    localparam int POS_POLARITY = 2;

    // blink config fields
    localparam int POS_BLINK_RATE = 0;
    localparam int POS_STRETCH_BYPASS = 2;
    localparam logic [1:0] BLINK_SEL_20HZ = 2'h0;
    localparam logic [1:0] BLINK_SEL_10HZ = 2'h1;
    localparam logic [1:0] BLINK_SEL_5HZ = 2'h2;

    // general config four fields
    localparam int POS_FAST_NEG_EN = 14;
    localparam int POS_FAST_NEG_SEL = 12;
    localparam int POS_PD_FULL_DUPLEX = 11;
    localparam int POS_STATUS_RESTART = 10;
    localparam int POS_ROBUST_XOVER = 9;
    localparam int POS_FAST_XOVER = 8;
    localparam int POS_INT_OE = 7;
    localparam int POS_FORCE_INT = 6;
    localparam int POS_GIG_FORCED_NEG = 3;
    localparam int POS_TEST_FAIL = 2;
    localparam int POS_TEST_DONE = 1;
    localparam int POS_TEST_START = 0;
    localparam logic RST_TEST_DONE = 1'b1;

    // interrupt status bits
    localparam int IRQ_TEST_DONE = 0;
    localparam int IRQ_TEST_FAIL = 1;
    localparam int IRQ_POWERDOWN = 2;

    // timing
    localparam int CLK_KHZ = 200_000;
    localparam int BLINK_20HZ_MS = 50;
    localparam int BLINK_10HZ_MS = 100;
    localparam int BLINK_5HZ_MS = 200;
    localparam int BLINK_2HZ_MS = 500;
    localparam int STRETCH_MS = 50;
    localparam int BLINK_20HZ_CYCLES = BLINK_20HZ_MS * CLK_KHZ;
    localparam int BLINK_10HZ_CYCLES = BLINK_10HZ_MS * CLK_KHZ;
    localparam int BLINK_5HZ_CYCLES = BLINK_5HZ_MS * CLK_KHZ;
    localparam int BLINK_2HZ_CYCLES = BLINK_2HZ_MS * CLK_KHZ;
    localparam int STRETCH_CYCLES = STRETCH_MS * CLK_KHZ;

    typedef struct packed {
        logic fast_negotiation_enable;
        logic [1:0] fast_negotiation_timer_sel;
        logic parallel_detect_full_duplex_enable;
        logic robust_crossover_enable;
        logic fast_crossover_enable;
    } phy_option_type;

    typedef struct packed {
        logic polarity;
        logic force_value;
        logic force_enable;
    } indicator_ctrl_type;

endpackage

/* File: rtl/phy_indicator_and_general_config.sv */
// indicator polarity/override, blink and general config registers behind an apb slave
// How it works
// - bit 14 sets the general-purpose indicator polarity, 1 active high, reset active high.
// - bits 10, 6 and 2 set the polarity of indicators two, one and zero, reset active high.
// - with bit 12 set the general-purpose indicator is driven with bit 13, else it works normally.
// - with bit 8 set indicator two is driven with bit 9, else it works normally.
// - with bit 4 set indicator one is driven with bit 5, else it works normally.
// - with bit 0 set indicator zero is driven with bit 1, else it works normally.
// - the blink rate field picks 20, 10, 5 or 2 hz blinking and resets to the 5 hz code.
// - bit 2 of the blink config bypasses the stretching of indicator activity.
// - fast negotiation enable with a timer select from shortest (0) to longest (2) is passed out.
// - bit 11 lets a parallel-detected link be declared full duplex.
// - while the status-restart bit is set the latched phy status bits are held cleared.
// - bits 9 and 8 enable robust and fast crossover resolution, both off at reset.
// - bit 7 turns the shared pad into an interrupt output, else it is a power-down input.
// - bit 6 asserts the interrupt pad regardless of events.
// - bit 3 with a 1g manual speed requests negotiation advertising only 1g.
//
// Register access over APB is this design's own decision.
module phy_indicator_and_general_config #(
    parameter int BLINK_20HZ_CYCLES = phy_cfg_pkg::BLINK_20HZ_CYCLES,
    parameter int BLINK_10HZ_CYCLES = phy_cfg_pkg::BLINK_10HZ_CYCLES,
    parameter int BLINK_5HZ_CYCLES = phy_cfg_pkg::BLINK_5HZ_CYCLES,
    parameter int BLINK_2HZ_CYCLES = phy_cfg_pkg::BLINK_2HZ_CYCLES,
    parameter int STRETCH_CYCLES = phy_cfg_pkg::STRETCH_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic [phy_cfg_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [phy_cfg_pkg::DATA_W-1:0] pwdata,
    output logic [phy_cfg_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [phy_cfg_pkg::IND_N-1:0] indicator_link,
    input wire logic [phy_cfg_pkg::IND_N-1:0] indicator_activity,
    output logic gp_indicator_out,
    output logic indicator_two_out,
    output logic indicator_one_out,
    output logic indicator_zero_out,
    output phy_cfg_pkg::phy_option_type phy_options,
    input wire logic manual_speed_1g,
    output logic gigabit_only_negotiation,
    output logic status_bits_clear,
    input wire logic core_interrupt,
    input wire logic irq_pad_in,
    output logic irq_pad_out,
    output logic irq_pad_oe,
    output logic powerdown_request,
    output logic reflect_test_run,
    input wire logic reflect_test_complete,
    input wire logic reflect_test_failed,
    output logic irq
);

    localparam int RW = phy_cfg_pkg::REG_W;
    localparam int CW = phy_cfg_pkg::CNT_W;

    typedef enum logic {test_idle, test_running} test_state_type;

    function automatic logic addr_hit(input logic [phy_cfg_pkg::ADDR_W-1:0] addr,
                                      input logic [phy_cfg_pkg::ADDR_W-1:0] reg_addr);
        addr_hit = (addr == reg_addr);
    endfunction

    function automatic phy_cfg_pkg::indicator_ctrl_type ind_ctrl(input logic [RW-1:0] cfg,
                                                                 input int idx);
        int base;
        base = idx * phy_cfg_pkg::IND_NIBBLE;
        ind_ctrl.polarity = cfg[base + phy_cfg_pkg::POS_POLARITY];
        ind_ctrl.force_value = cfg[base + phy_cfg_pkg::POS_FORCE_VALUE];
        ind_ctrl.force_enable = cfg[base + phy_cfg_pkg::POS_FORCE_ENABLE];
    endfunction

    logic [RW-1:0] indicator_polarity_override;
    logic [RW-1:0] indicator_blink_config;
    logic [RW-1:0] general_rw;
    logic test_start;
    logic test_done;
    logic test_fail;
    test_state_type test_state;
    logic [phy_cfg_pkg::IRQ_W-1:0] irq_status;
    logic [phy_cfg_pkg::IRQ_W-1:0] irq_enable;
    logic pad_sync1;
    logic pad_sync2;
    logic powerdown_prev;
    logic [CW-1:0] blink_count;
    logic blink_phase;
    logic [phy_cfg_pkg::IND_N-1:0] indicator_pins;

    // apb decode
    wire setup_phase = psel & ~penable;
    wire write_fire = psel & penable & pready & pwrite;
    wire hit_led = addr_hit(paddr, phy_cfg_pkg::ADDR_INDICATOR_POLARITY_OVERRIDE);
    wire hit_blink = addr_hit(paddr, phy_cfg_pkg::ADDR_INDICATOR_BLINK_CONFIG);
    wire hit_general = addr_hit(paddr, phy_cfg_pkg::ADDR_GENERAL_CONFIG_FOUR);
    wire hit_status = addr_hit(paddr, phy_cfg_pkg::ADDR_IRQ_STATUS);
    wire hit_clear = addr_hit(paddr, phy_cfg_pkg::ADDR_IRQ_CLEAR);
    wire hit_enable = addr_hit(paddr, phy_cfg_pkg::ADDR_IRQ_ENABLE);
    wire mapped = hit_led | hit_blink | hit_general | hit_status | hit_clear | hit_enable;
    wire [RW-1:0] wr_value = pwdata[RW-1:0];

    wire [RW-1:0] general_value = general_rw |
        (RW'(test_fail) << phy_cfg_pkg::POS_TEST_FAIL) |
        (RW'(test_done) << phy_cfg_pkg::POS_TEST_DONE) |
        (RW'(test_start) << phy_cfg_pkg::POS_TEST_START);

    // the clear register reads as zero
    wire [RW-1:0] rd_value =
        hit_led ? indicator_polarity_override :
        hit_blink ? indicator_blink_config :
        hit_general ? general_value :
        hit_status ? RW'(irq_status) :
        hit_enable ? RW'(irq_enable) : '0;

    // zero wait states: answer registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= phy_cfg_pkg::RDATA_ZERO;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= setup_phase;
            pslverr <= setup_phase & ~mapped;
            if (setup_phase) begin
                prdata <= {{(phy_cfg_pkg::DATA_W - RW){1'b0}}, rd_value};
            end
        end
    end

    // configuration registers; reserved bits masked so they read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            indicator_polarity_override <= phy_cfg_pkg::RST_INDICATOR_POLARITY_OVERRIDE;
            indicator_blink_config <= phy_cfg_pkg::RST_INDICATOR_BLINK_CONFIG;
            general_rw <= phy_cfg_pkg::RST_GENERAL_CONFIG_FOUR & phy_cfg_pkg::MASK_GENERAL_CONFIG_RW;
            irq_enable <= '0;
        end else if (clk_en && write_fire) begin
            if (hit_led) begin
                indicator_polarity_override <= wr_value & phy_cfg_pkg::MASK_INDICATOR_POLARITY_OVERRIDE;
            end
            if (hit_blink) begin
                indicator_blink_config <= wr_value & phy_cfg_pkg::MASK_INDICATOR_BLINK_CONFIG;
            end
            if (hit_general) begin
                general_rw <= wr_value & phy_cfg_pkg::MASK_GENERAL_CONFIG_RW;
            end
            if (hit_enable) begin
                irq_enable <= wr_value[phy_cfg_pkg::IRQ_W-1:0];
            end
        end
    end

    // reflectometry test handshake with the tdr engine
    wire start_write = write_fire & hit_general & wr_value[phy_cfg_pkg::POS_TEST_START];
    wire test_finish = (test_state == test_running) & reflect_test_complete;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_state <= test_idle;
            test_start <= 1'b0;
            test_done <= phy_cfg_pkg::RST_TEST_DONE;
            test_fail <= 1'b0;
        end else if (clk_en) begin
            case (test_state)
                test_idle: begin
                    // writing 0 never aborts; a start while running is ignored
                    if (start_write) begin
                        test_state <= test_running;
                        test_start <= 1'b1;
                        test_done <= 1'b0;
                        test_fail <= 1'b0;
                    end
                end
                test_running: begin
                    if (reflect_test_complete) begin
                        test_state <= test_idle;
                        test_start <= 1'b0;
                        test_done <= 1'b1;
                        test_fail <= reflect_test_failed;
                    end
                end
                default: begin
                    test_state <= test_idle;
                    test_start <= 1'b0;
                end
            endcase
        end
    end

    // shared pad: sync the input before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_sync1 <= 1'b1;
            pad_sync2 <= 1'b1;
        end else if (clk_en) begin
            pad_sync1 <= irq_pad_in;
            pad_sync2 <= pad_sync1;
        end
    end

    wire int_oe = general_rw[phy_cfg_pkg::POS_INT_OE];
    wire powerdown_level = ~int_oe & ~pad_sync2;
    wire powerdown_rise = powerdown_level & ~powerdown_prev;

    // sticky status: a set in the clearing cycle wins
    wire [phy_cfg_pkg::IRQ_W-1:0] irq_events =
        (phy_cfg_pkg::IRQ_W'(test_finish) << phy_cfg_pkg::IRQ_TEST_DONE) |
        (phy_cfg_pkg::IRQ_W'(test_finish & reflect_test_failed) << phy_cfg_pkg::IRQ_TEST_FAIL) |
        (phy_cfg_pkg::IRQ_W'(powerdown_rise) << phy_cfg_pkg::IRQ_POWERDOWN);
    wire [phy_cfg_pkg::IRQ_W-1:0] irq_clear_bits =
        (write_fire & hit_clear) ? wr_value[phy_cfg_pkg::IRQ_W-1:0] : '0;
    wire [phy_cfg_pkg::IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clear_bits) | irq_events;
    wire interrupt_asserted = general_rw[phy_cfg_pkg::POS_FORCE_INT] | core_interrupt |
                              (|(next_irq_status & irq_enable));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
            powerdown_prev <= 1'b0;
            irq <= 1'b0;
            irq_pad_out <= 1'b0;
            irq_pad_oe <= 1'b0;
            powerdown_request <= 1'b0;
        end else if (clk_en) begin
            irq_status <= next_irq_status;
            powerdown_prev <= powerdown_level;
            irq <= |(next_irq_status & irq_enable);
            // open drain, active low: only ever pulls the pad low
            irq_pad_out <= 1'b0;
            irq_pad_oe <= int_oe & interrupt_asserted;
            powerdown_request <= powerdown_level;
        end
    end

    // general options to the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_options <= '0;
            gigabit_only_negotiation <= 1'b0;
            status_bits_clear <= 1'b0;
            reflect_test_run <= 1'b0;
        end else if (clk_en) begin
            phy_options.fast_negotiation_enable <= general_rw[phy_cfg_pkg::POS_FAST_NEG_EN];
            // timer select only means something with fast negotiation on
            phy_options.fast_negotiation_timer_sel <=
                general_rw[phy_cfg_pkg::POS_FAST_NEG_SEL +: 2];
            phy_options.parallel_detect_full_duplex_enable <=
                general_rw[phy_cfg_pkg::POS_PD_FULL_DUPLEX];
            phy_options.robust_crossover_enable <= general_rw[phy_cfg_pkg::POS_ROBUST_XOVER];
            phy_options.fast_crossover_enable <= general_rw[phy_cfg_pkg::POS_FAST_XOVER];
            gigabit_only_negotiation <=
                general_rw[phy_cfg_pkg::POS_GIG_FORCED_NEG] & manual_speed_1g;
            status_bits_clear <= general_rw[phy_cfg_pkg::POS_STATUS_RESTART];
            reflect_test_run <= test_start;
        end
    end

    // blink timebase: phase toggles every half period of the selected rate
    wire [1:0] blink_rate_sel = indicator_blink_config[phy_cfg_pkg::POS_BLINK_RATE +: 2];
    wire stretch_bypass = indicator_blink_config[phy_cfg_pkg::POS_STRETCH_BYPASS];
    wire [CW-1:0] blink_half =
        (blink_rate_sel == phy_cfg_pkg::BLINK_SEL_20HZ) ? CW'(BLINK_20HZ_CYCLES / 2) :
        (blink_rate_sel == phy_cfg_pkg::BLINK_SEL_10HZ) ? CW'(BLINK_10HZ_CYCLES / 2) :
        (blink_rate_sel == phy_cfg_pkg::BLINK_SEL_5HZ) ? CW'(BLINK_5HZ_CYCLES / 2) :
        CW'(BLINK_2HZ_CYCLES / 2);

    // >= so a rate change to a shorter period never overruns the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_count <= '0;
            blink_phase <= 1'b0;
        end else if (clk_en) begin
            if (blink_count >= blink_half - CW'(1)) begin
                blink_count <= '0;
                blink_phase <= ~blink_phase;
            end else begin
                blink_count <= blink_count + CW'(1);
            end
        end
    end

    // per indicator: stretch activity, blink while active, else show link
    for (genvar i = 0; i < phy_cfg_pkg::IND_N; i++) begin : g_ind
        logic [CW-1:0] stretch_count;
        phy_cfg_pkg::indicator_ctrl_type ctrl;
        logic held;
        logic normal;
        logic next_pin;

        assign ctrl = ind_ctrl(indicator_polarity_override, i);
        assign held = stretch_bypass ? indicator_activity[i] :
                      (indicator_activity[i] | (stretch_count != '0));
        assign normal = held ? blink_phase : indicator_link[i];
        // forced value goes to the pin as written, polarity not applied
        assign next_pin = ctrl.force_enable ? ctrl.force_value :
                          (ctrl.polarity ? normal : ~normal);

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stretch_count <= '0;
                indicator_pins[i] <= 1'b0;
            end else if (clk_en) begin
                if (indicator_activity[i]) begin
                    stretch_count <= CW'(STRETCH_CYCLES - 1);
                end else if (stretch_count != '0) begin
                    stretch_count <= stretch_count - CW'(1);
                end
                indicator_pins[i] <= next_pin;
            end
        end
    end

    assign indicator_zero_out = indicator_pins[0];
    assign indicator_one_out = indicator_pins[1];
    assign indicator_two_out = indicator_pins[2];
    assign gp_indicator_out = indicator_pins[3];

endmodule // phy_indicator_and_general_config

/* File: verif/phy_cfg_sva.sv */
// assertion checker for the indicator and general config register block
module phy_cfg_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [phy_cfg_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire phy_cfg_pkg::phy_option_type phy_options,
    input wire logic manual_speed_1g,
    input wire logic gigabit_only_negotiation,
    input wire logic status_bits_clear,
    input wire logic irq_pad_oe,
    input wire logic powerdown_request,
    input wire logic reflect_test_run,
    input wire logic reflect_test_complete
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic write_done = psel && penable && pwrite && pready;

    answer_time_a: assert property (psel && !penable && clk_en |=> pready)
        else $error("setup not answered in one cycle");
    error_pair_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    gig_speed_a: assert property (gigabit_only_negotiation |-> $past(manual_speed_1g))
        else $error("gigabit negotiation without 1g speed");
    pad_use_a: assert property (!(irq_pad_oe && powerdown_request))
        else $error("pad used both ways");
    test_stop_a: assert property (
        reflect_test_run && reflect_test_complete |-> ##2 !reflect_test_run)
        else $error("test kept running after completion");
    run_fall_a: assert property ($fell(reflect_test_run) |-> $past(reflect_test_complete, 2))
        else $error("test stopped without completion");
    restart_hold_a: assert property ($changed(status_bits_clear) |-> $past(write_done, 2))
        else $error("restart level moved without a write");
    option_hold_a: assert property ($changed(phy_options) |-> $past(write_done, 2))
        else $error("options moved without a write");

    cover property (write_done && pslverr);
    cover property (reflect_test_run && reflect_test_complete);
    cover property ($rose(powerdown_request));
endmodule // phy_cfg_sva

bind phy_indicator_and_general_config phy_cfg_sva checker_i (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .prdata, .pready, .pslverr, .phy_options, .manual_speed_1g,
    .gigabit_only_negotiation, .status_bits_clear, .irq_pad_oe, .powerdown_request,
    .reflect_test_run, .reflect_test_complete);

/* File: verif/test_phy_indicator_and_general_config.sv */
// self-checking testbench for the indicator and general config register block
module test_phy_indicator_and_general_config;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdata, w;
    logic pready, pslverr, gp_indicator_out, indicator_two_out, indicator_one_out, irq;
    logic indicator_zero_out, gigabit_only_negotiation, status_bits_clear, irq_pad_out;
    logic irq_pad_oe, powerdown_request, reflect_test_run, irq_pad_in = 1;
    logic [3:0] indicator_link = 4'h0, indicator_activity = 4'h0;
    logic manual_speed_1g = 0, core_interrupt = 0;
    logic reflect_test_complete = 0, reflect_test_failed = 0;
    phy_cfg_pkg::phy_option_type phy_options;
    int checks = 0, miscompares = 0, i, k;
    wire logic [3:0] pins = {gp_indicator_out, indicator_two_out, indicator_one_out,
        indicator_zero_out};

    // blink and stretch counts shortened so the run stays brief
    phy_indicator_and_general_config #(.BLINK_20HZ_CYCLES(8), .BLINK_10HZ_CYCLES(16),
        .BLINK_5HZ_CYCLES(32), .BLINK_2HZ_CYCLES(80), .STRETCH_CYCLES(5)) DUT (
        .pclk, .presetn, .clk_en, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .indicator_link, .indicator_activity, .gp_indicator_out, .indicator_two_out,
        .indicator_one_out, .indicator_zero_out, .phy_options, .manual_speed_1g,
        .gigabit_only_negotiation, .status_bits_clear, .core_interrupt, .irq_pad_in,
        .irq_pad_out, .irq_pad_oe, .powerdown_request, .reflect_test_run,
        .reflect_test_complete, .reflect_test_failed, .irq);

    always #2.5 pclk = ~pclk;

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask

    // one transfer, then an idle edge so psel is never driven twice in a step
    // no local limit on the wait: only the watchdog ends a hung transfer
    task automatic apb(input logic dir, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= dir;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, rdata, e);
    endtask

    task automatic settle();
        repeat (2) @(posedge pclk);
    endtask

    task automatic finish_test(input logic f);
        reflect_test_complete <= 1'b1;
        reflect_test_failed <= f;
        @(posedge pclk);
        reflect_test_complete <= 1'b0;
        reflect_test_failed <= 1'b0;
        settle();
    endtask

    function automatic logic exp_pin(input int n);
        return w[4*n] ? w[4*n+1] : (w[4*n+2] ? indicator_link[n] : !indicator_link[n]);
    endfunction

    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #200_000;
        miscompares++;
        final_report();
    end

    initial begin
        void'($urandom(32'h3a31));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk("polarity reg", 8'h64, 32'h0000_4444);
        rchk("blink reg", 8'h68, 32'h0000_0002);
        rchk("general reg", 8'h78, 32'h0000_0012);
        $display("reset value test done");
        for (i = 0; i < 6; i++) begin
            w = $urandom & 32'h0000_7777;
            indicator_link <= 4'($urandom);
            wr(8'h64, w);
            settle();
            for (k = 0; k < 4; k++)
                chk("pin", 32'(pins[k]), 32'(exp_pin(k)));
            rchk("polarity reg", 8'h64, w);
        end
        // steady activity on indicator zero shows the blink phase; skip a partial half and one full half
        wr(8'h64, 32'h0000_4444);
        indicator_activity <= 4'h1;
        wr(8'h68, 32'h0000_0000);
        for (i = 0; i < 3; i++) begin
            w[0] = indicator_zero_out;
            k = 0;
            do begin @(posedge pclk); k++; end while (indicator_zero_out === w[0]);
        end
        chk("blink half", 32'(k), 32'h0000_0004);
        clk_en <= 1'b0;
        @(posedge pclk);
        w[1] = indicator_zero_out;
        repeat (6) @(posedge pclk);
        chk("frozen pin", 32'(indicator_zero_out), 32'(w[1]));
        clk_en <= 1'b1;
        indicator_activity <= 4'h0;
        w = $urandom & 32'h0000_0007;
        wr(8'h68, w | 32'h0000_fff0);
        rchk("blink reg", 8'h68, w);
        $display("indicator test done");
        for (i = 0; i < 6; i++) begin
            w = $urandom & 32'h0000_fffe;
            manual_speed_1g <= 1'($urandom);
            core_interrupt <= 1'($urandom);
            wr(8'h78, w);
            settle();
            chk("options", 32'(phy_options), 32'({w[14:11], w[9:8]}));
            chk("restart", 32'(status_bits_clear), 32'(w[10]));
            chk("gig", 32'(gigabit_only_negotiation), 32'(w[3] & manual_speed_1g));
            chk("pad oe", 32'(irq_pad_oe), 32'(w[7] & (w[6] | core_interrupt)));
            rchk("general reg", 8'h78, (w & 32'h0000_fff8) | 32'h0000_0002);
        end
        wr(8'hfc, 32'h0000_ffff);
        chk("error", 32'(err), 32'h0000_0001);
        rchk("unmapped", 8'hfc, 32'h0000_0000);
        $display("general config test done");
        wr(8'h88, 32'h0000_0003);
        wr(8'h78, 32'h0000_0001);
        settle();
        chk("running", 32'(reflect_test_run), 32'h0000_0001);
        rchk("general reg", 8'h78, 32'h0000_0001);
        finish_test(1'b1);
        chk("running", 32'(reflect_test_run), 32'h0000_0000);
        chk("irq", 32'(irq), 32'h0000_0001);
        rchk("general reg", 8'h78, 32'h0000_0006);
        rchk("status", 8'h80, 32'h0000_0003);
        wr(8'h84, 32'h0000_0003);
        settle();
        chk("irq", 32'(irq), 32'h0000_0000);
        finish_test(1'b1);
        rchk("status", 8'h80, 32'h0000_0000);
        wr(8'h78, 32'h0000_0001);
        finish_test(1'b0);
        rchk("general reg", 8'h78, 32'h0000_0002);
        wr(8'h84, 32'h0000_0007);
        $display("reflect test done");
        irq_pad_in <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("powerdown", 32'(powerdown_request), 32'h0000_0001);
        chk("irq", 32'(irq), 32'h0000_0000);
        rchk("status", 8'h80, 32'h0000_0004);
        wr(8'h88, 32'h0000_0007);
        settle();
        chk("irq", 32'(irq), 32'h0000_0001);
        wr(8'h84, 32'h0000_0004);
        core_interrupt <= 1'b1;
        wr(8'h78, 32'h0000_0080);
        settle();
        chk("irq", 32'(irq), 32'h0000_0000);
        chk("powerdown", 32'(powerdown_request), 32'h0000_0000);
        chk("pad oe", 32'(irq_pad_oe), 32'h0000_0001);
        $display("interrupt test done");
        final_report();
    end
endmodule // test_phy_indicator_and_general_config
